/* File: core/usbc_pkg.sv */
// Constants, types and decoders shared by the sample and baud logic
package usbc_pkg;

	// Register byte addresses
	localparam logic [7:0] ADR_CTRL  = 8'h00;
	localparam logic [7:0] ADR_OVR   = 8'h04;
	localparam logic [7:0] ADR_PSR   = 8'h08;
	localparam logic [7:0] ADR_BAUD  = 8'h0c;
	localparam logic [7:0] ADR_MDSL2 = 8'h10;
	localparam logic [7:0] ADR_SPOS  = 8'h14;
	localparam logic [7:0] ADR_STAT  = 8'h18;

	// Reset values
	localparam logic [7:0]  RST_CTRL  = 8'h00;
	localparam logic [7:0]  RST_OVR   = 8'h00;
	localparam logic [7:0]  RST_PSR   = 8'h00;
	localparam logic [15:0] RST_BAUD  = 16'h0000;
	localparam logic [7:0]  RST_MDSL2 = 8'h00;
	localparam logic [7:0]  RST_SPOS  = 8'h06;

	// Field positions
	localparam int CTRL_SYNC_BIT = 0;
	localparam int CTRL_CKS_BIT  = 1;
	localparam int MDSL2_SMD_BIT = 0;
	localparam int STAT_BIT_BIT  = 0;
	localparam int STAT_PIN_BIT  = 1;
	localparam int STAT_SYNC_BIT = 2;

	// Oversample decode
	localparam logic [3:0] OVS_MIN_CODE = 4'h7;
	localparam logic [4:0] OVS_DEFAULT  = 5'h10;
	// Prescaler code plus this is the factor in half steps
	localparam logic [5:0] PSR_HALF_BASE = 6'h02;
	// Accumulator step per clock, in half cycles
	localparam logic [23:0] ACC_STEP = 24'h000002;

	typedef enum logic [2:0] {
		USBC_ASYNC    = 3'b001,
		USBC_SYNC_INT = 3'b010,
		USBC_SYNC_EXT = 3'b100
	} usbc_mode_t;

	// Oversample rate from the 4-bit rate code
	function automatic logic [4:0] usbc_rate(input logic [3:0] code);
		usbc_rate = (code < OVS_MIN_CODE) ? OVS_DEFAULT : {1'b0, code};
	endfunction

	// Automatic first sample period for a rate of 7 to 16
	function automatic logic [3:0] usbc_auto_pos(input logic [4:0] rate);
		logic [4:0] t;
		t = (rate - 5'h03) >> 1;
		usbc_auto_pos = t[3:0];
	endfunction

endpackage

/* File: core/usbc_baud_gen.sv */
// Fractional baud tick generator, half-step prescaler resolution
module usbc_baud_gen
	import usbc_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// Settings
	input  wire logic [15:0] divisor,
	input  wire logic [4:0]  presc_code,
	// Tick at clock / (N * P)
	output logic             tick_q
);
	import usbc_pkg::*;

	logic [23:0] acc_q;
	logic [23:0] acc_d;
	logic        tick_d;
	logic [23:0] target;
	logic [23:0] sum;

	// Period in half cycles is 2P * (divisor + 1)
	assign target = 24'({1'b0, presc_code} + PSR_HALF_BASE)
		* 24'({1'b0, divisor} + 17'h00001);
	assign sum = acc_q + ACC_STEP;

	always_comb begin
		if (acc_q >= target) begin
			// Period shrank under a stale count: restart, no tick burst
			acc_d  = 24'h000000;
			tick_d = 1'b1;
		end else if (sum >= target) begin
			acc_d  = sum - target;
			tick_d = 1'b1;
		end else begin
			acc_d  = sum;
			tick_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q  <= 24'h000000;
			tick_q <= 1'b0;
		end else begin
			acc_q  <= acc_d;
			tick_q <= tick_d;
		end
	end

	// Gap between ticks, checked while settings hold
	logic [23:0] gap_q;
	logic        gap_ok_q;
	logic [23:0] tgt_q;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			gap_q    <= 24'h000000;
			gap_ok_q <= 1'b0;
			tgt_q    <= 24'h000000;
		end else begin
			tgt_q    <= target;
			gap_q    <= tick_q ? 24'h000001 : gap_q + 24'h000001;
			gap_ok_q <= (target != tgt_q) ? 1'b0 : (tick_q | gap_ok_q);
		end
	end

	property p_tick_gap;
		@(posedge core_clk) disable iff (!reset_n)
		(tick_q && gap_ok_q && target == tgt_q)
			|-> (gap_q * 2 + 1 >= target) && (gap_q * 2 <= target + 1);
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("baud tick spacing off");

	c_half_step: cover property (@(posedge core_clk) disable iff (!reset_n)
		tick_q && gap_ok_q && target[0]);
endmodule

/* File: core/usbc_sampler.sv */
// Oversample counter, three-point sampling and majority vote
module usbc_sampler
	import usbc_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// Timing
	input  wire logic       os_tick,
	input  wire logic       restart,
	input  wire logic [4:0] rate,
	input  wire logic [3:0] start_pos,
	// Serial data
	input  wire logic       rx_in,
	// Result
	output logic            bit_done_q,
	output logic            bit_value_q
);
	import usbc_pkg::*;

	logic [4:0] idx_q;
	logic [4:0] idx_d;
	logic [2:0] smp_q;
	logic [2:0] smp_d;
	logic       bit_done_d;
	logic       bit_value_d;
	logic       wrap;
	logic       vote;

	assign wrap = (idx_q >= rate - 5'h01);
	assign vote = (smp_d[0] & smp_d[1]) | (smp_d[0] & smp_d[2])
		| (smp_d[1] & smp_d[2]);

	// One capture point per sample, consecutive periods
	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_smp
			always_comb begin
				if (restart)
					smp_d[k] = 1'b0;
				else if (os_tick && idx_q == {1'b0, start_pos} + 5'(k))
					smp_d[k] = rx_in;
				else
					smp_d[k] = smp_q[k];
			end
		end
	endgenerate

	always_comb begin
		idx_d       = idx_q;
		bit_done_d  = 1'b0;
		bit_value_d = bit_value_q;
		if (restart) begin
			idx_d = 5'h00;
		end else if (os_tick) begin
			if (wrap) begin
				idx_d       = 5'h00;
				bit_done_d  = 1'b1;
				bit_value_d = vote;
			end else begin
				idx_d = idx_q + 5'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_q       <= 5'h00;
			smp_q       <= 3'b000;
			bit_done_q  <= 1'b0;
			bit_value_q <= 1'b0;
		end else begin
			idx_q       <= idx_d;
			smp_q       <= smp_d;
			bit_done_q  <= bit_done_d;
			bit_value_q <= bit_value_d;
		end
	end

	property p_idx_range;
		@(posedge core_clk) disable iff (!reset_n)
		$past(os_tick) && !$past(restart) && $stable(rate) |-> idx_q < rate;
	endproperty
	a_idx_range: assert property (p_idx_range)
		else $error("oversample index out of range");

	property p_first_sample;
		@(posedge core_clk) disable iff (!reset_n)
		(os_tick && !restart && idx_q == {1'b0, start_pos})
			|=> smp_q[0] == $past(rx_in);
	endproperty
	a_first_sample: assert property (p_first_sample)
		else $error("first sample not taken at start position");

	property p_vote;
		@(posedge core_clk) disable iff (!reset_n)
		bit_done_q |-> bit_value_q == ((smp_q[0] & smp_q[1])
			| (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]));
	endproperty
	a_vote: assert property (p_vote)
		else $error("bit value is not the majority of samples");
endmodule

/* File: core/usbc_top.sv */
// Sample position and baud generation block with Wishbone registers
module usbc_top
	import usbc_pkg::*;
#(
	parameter bit FIRST_INSTANCE = 1'b1
)
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// Wishbone slave
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Serial receive data and bit timing
	input  wire logic        rx_in,
	input  wire logic        rx_restart,
	output logic             rx_bit_done,
	output logic             rx_bit_value,
	// Synchronous clock pin
	input  wire logic        sync_clock_pin_i,
	output logic             sync_clock_pin_o,
	output logic             sync_clock_pin_oe_n,
	output logic             sync_bit_strobe
);
	import usbc_pkg::*;

	// Register state
	logic [7:0]  ctrl_q;
	logic [7:0]  ctrl_d;
	logic [7:0]  oversample_rate_reg_q;
	logic [7:0]  oversample_rate_reg_d;
	logic [7:0]  prescaler_reg_q;
	logic [7:0]  prescaler_reg_d;
	logic [15:0] baud_divisor_reg_q;
	logic [15:0] baud_divisor_reg_d;
	logic [7:0]  mode_select_two_reg_q;
	logic [7:0]  mode_select_two_reg_d;
	logic [7:0]  sample_position_reg_q;
	logic [7:0]  sample_position_reg_d;
	logic        ack_d;
	logic [31:0] dat_d;

	// Pin state
	logic        pin_out_q;
	logic        pin_out_d;
	logic        pin_oe_n_q;
	logic        pin_oe_n_d;
	logic        pin_prev_q;
	logic        strobe_q;
	logic        strobe_d;

	logic        req;
	logic        wr;
	logic        os_tick;
	logic [4:0]  rate;
	logic [3:0]  start_pos;
	logic        sample_mode_select;
	logic [3:0]  sample_start_index;
	logic        bit_done;
	logic        bit_value;
	usbc_mode_t  mode;

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr  = req & wb_we_i;

	assign rate = usbc_rate(oversample_rate_reg_q[3:0]);
	assign sample_mode_select = mode_select_two_reg_q[MDSL2_SMD_BIT];
	assign sample_start_index = sample_position_reg_q[3:0];

	// Manual position only while the mode bit is set
	assign start_pos = sample_mode_select ? sample_start_index
		: usbc_auto_pos(rate);

	always_comb begin
		if (!ctrl_q[CTRL_SYNC_BIT])
			mode = USBC_ASYNC;
		else if (ctrl_q[CTRL_CKS_BIT])
			mode = USBC_SYNC_EXT;
		else
			mode = USBC_SYNC_INT;
	end

	// Register writes
	always_comb begin
		ctrl_d                = ctrl_q;
		oversample_rate_reg_d = oversample_rate_reg_q;
		prescaler_reg_d       = prescaler_reg_q;
		baud_divisor_reg_d    = baud_divisor_reg_q;
		mode_select_two_reg_d = mode_select_two_reg_q;
		sample_position_reg_d = sample_position_reg_q;
		if (wr && wb_sel_i[0]) begin
			case (wb_adr_i)
				ADR_CTRL: begin
					// Sync bits exist only on the first instance
					ctrl_d = FIRST_INSTANCE ? {6'h00, wb_dat_i[1:0]}
						: 8'h00;
				end
				ADR_OVR:   oversample_rate_reg_d = {4'h0, wb_dat_i[3:0]};
				ADR_PSR:   prescaler_reg_d = {3'h0, wb_dat_i[4:0]};
				ADR_BAUD:  baud_divisor_reg_d[7:0] = wb_dat_i[7:0];
				ADR_MDSL2: mode_select_two_reg_d = {7'h00, wb_dat_i[0]};
				ADR_SPOS:  sample_position_reg_d = {4'h0, wb_dat_i[3:0]};
				default:   ;
			endcase
		end
		if (wr && wb_sel_i[1] && wb_adr_i == ADR_BAUD)
			baud_divisor_reg_d[15:8] = wb_dat_i[15:8];
	end

	// Read mux, unmapped addresses read zero
	always_comb begin
		dat_d = 32'h00000000;
		ack_d = req;
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				ADR_CTRL:  dat_d = {24'h000000, ctrl_q};
				ADR_OVR:   dat_d = {24'h000000, oversample_rate_reg_q};
				ADR_PSR:   dat_d = {24'h000000, prescaler_reg_q};
				ADR_BAUD:  dat_d = {16'h0000, baud_divisor_reg_q};
				ADR_MDSL2: dat_d = {24'h000000, mode_select_two_reg_q};
				ADR_SPOS:  dat_d = {24'h000000, sample_position_reg_q};
				ADR_STAT: begin
					dat_d[STAT_BIT_BIT]  = bit_value;
					dat_d[STAT_PIN_BIT]  = sync_clock_pin_i;
					dat_d[STAT_SYNC_BIT] = ctrl_q[CTRL_SYNC_BIT];
				end
				default:   dat_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q                <= RST_CTRL;
			oversample_rate_reg_q <= RST_OVR;
			prescaler_reg_q       <= RST_PSR;
			baud_divisor_reg_q    <= RST_BAUD;
			mode_select_two_reg_q <= RST_MDSL2;
			sample_position_reg_q <= RST_SPOS;
			wb_ack_o              <= 1'b0;
			wb_dat_o              <= 32'h00000000;
		end else begin
			ctrl_q                <= ctrl_d;
			oversample_rate_reg_q <= oversample_rate_reg_d;
			prescaler_reg_q       <= prescaler_reg_d;
			baud_divisor_reg_q    <= baud_divisor_reg_d;
			mode_select_two_reg_q <= mode_select_two_reg_d;
			sample_position_reg_q <= sample_position_reg_d;
			wb_ack_o              <= ack_d;
			wb_dat_o              <= dat_d;
		end
	end

	usbc_baud_gen u_baud (
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.divisor    (baud_divisor_reg_q),
		.presc_code (prescaler_reg_q[4:0]),
		.tick_q     (os_tick)
	);

	usbc_sampler u_smp (
		.core_clk    (core_clk),
		.reset_n     (reset_n),
		.os_tick     (os_tick && mode == USBC_ASYNC),
		.restart     (rx_restart),
		.rate        (rate),
		.start_pos   (start_pos),
		.rx_in       (rx_in),
		.bit_done_q  (bit_done),
		.bit_value_q (bit_value)
	);

	assign rx_bit_done  = bit_done;
	assign rx_bit_value = bit_value;

	// Clock pin and synchronous bit strobe
	always_comb begin
		pin_out_d  = 1'b0;
		pin_oe_n_d = 1'b1;
		strobe_d   = 1'b0;
		case (mode)
			USBC_SYNC_INT: begin
				// Toggle per tick gives clock / (2 N P)
				pin_out_d  = os_tick ? ~pin_out_q : pin_out_q;
				pin_oe_n_d = 1'b0;
				strobe_d   = os_tick & ~pin_out_q;
			end
			USBC_SYNC_EXT: begin
				strobe_d = sync_clock_pin_i & ~pin_prev_q;
			end
			USBC_ASYNC: ;
			default: ;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_out_q  <= 1'b0;
			pin_oe_n_q <= 1'b1;
			pin_prev_q <= 1'b0;
			strobe_q   <= 1'b0;
		end else begin
			pin_out_q  <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
			pin_prev_q <= sync_clock_pin_i;
			strobe_q   <= strobe_d;
		end
	end

	assign sync_clock_pin_o    = pin_out_q;
	assign sync_clock_pin_oe_n = pin_oe_n_q;
	assign sync_bit_strobe     = strobe_q;

	property p_manual_pos;
		@(posedge core_clk) disable iff (!reset_n)
		sample_mode_select |-> start_pos == sample_position_reg_q[3:0];
	endproperty
	a_manual_pos: assert property (p_manual_pos)
		else $error("manual start position not used");

	property p_auto_pos;
		@(posedge core_clk) disable iff (!reset_n)
		!sample_mode_select && rate == 5'h10 |-> start_pos == 4'h6;
	endproperty
	a_auto_pos: assert property (p_auto_pos)
		else $error("automatic position wrong at rate sixteen");

	property p_rate_default;
		@(posedge core_clk) disable iff (!reset_n)
		oversample_rate_reg_q[3:0] < 4'h7 |-> rate == 5'h10;
	endproperty
	a_rate_default: assert property (p_rate_default)
		else $error("low rate code did not select sixteen");

	property p_spos_rsvd;
		@(posedge core_clk) disable iff (!reset_n)
		req && !wb_we_i && wb_adr_i == ADR_SPOS |=> wb_dat_o[31:4] == 28'h0;
	endproperty
	a_spos_rsvd: assert property (p_spos_rsvd)
		else $error("sample position reserved bits not zero");

	property p_sync_first;
		@(posedge core_clk) disable iff (!reset_n)
		!FIRST_INSTANCE |-> mode == USBC_ASYNC;
	endproperty
	a_sync_first: assert property (p_sync_first)
		else $error("sync mode on a later instance");

	property p_pin_drive;
		@(posedge core_clk) disable iff (!reset_n)
		mode == USBC_SYNC_INT |=> !sync_clock_pin_oe_n;
	endproperty
	a_pin_drive: assert property (p_pin_drive)
		else $error("clock pin not driven in internal sync mode");

	property p_ext_edge;
		@(posedge core_clk) disable iff (!reset_n)
		mode == USBC_SYNC_EXT && sync_clock_pin_i && !pin_prev_q
			|=> sync_bit_strobe && sync_clock_pin_oe_n;
	endproperty
	a_ext_edge: assert property (p_ext_edge)
		else $error("external clock edge missed");

	property p_toggle_tick;
		@(posedge core_clk) disable iff (!reset_n)
		$past(mode == USBC_SYNC_INT) && $changed(pin_out_q) |-> $past(os_tick);
	endproperty
	a_toggle_tick: assert property (p_toggle_tick)
		else $error("clock pin toggled without a tick");

	property p_ack_pulse;
		@(posedge core_clk) disable iff (!reset_n)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held longer than one cycle");

	property p_auto_low;
		@(posedge core_clk) disable iff (!reset_n)
		!sample_mode_select && rate == 5'h07 |-> start_pos == 4'h2;
	endproperty
	a_auto_low: assert property (p_auto_low)
		else $error("automatic position wrong at rate seven");

	property p_async_quiet;
		@(posedge core_clk) disable iff (!reset_n)
		mode == USBC_ASYNC |=> sync_clock_pin_oe_n && !sync_bit_strobe;
	endproperty
	a_async_quiet: assert property (p_async_quiet)
		else $error("clock pin active in asynchronous mode");

	c_manual: cover property (@(posedge core_clk) disable iff (!reset_n)
		sample_mode_select && rx_bit_done);
	c_auto: cover property (@(posedge core_clk) disable iff (!reset_n)
		!sample_mode_select && rx_bit_done);
	c_sync_int: cover property (@(posedge core_clk) disable iff (!reset_n)
		mode == USBC_SYNC_INT && sync_bit_strobe);
	c_sync_ext: cover property (@(posedge core_clk) disable iff (!reset_n)
		mode == USBC_SYNC_EXT && sync_bit_strobe);
endmodule

/* File: testbench/usbc_far_end.sv */
// Far side model: external bit clock source on the clock pin
module usbc_far_end (
	// Clock
	input  wire logic       core_clk,
	// Control from the bench
	input  wire logic       run,
	input  wire logic [3:0] half,
	// Pin drive and count of rising edges sent
	output logic            drv,
	output logic            lvl,
	output int              rises
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	initial begin
		drv = 1'b0;
		lvl = 1'b0;
		rises = 0;
		cnt = 4'h0;
	end
	// Clock stands low between bursts, then pin is released
	always @(posedge core_clk) begin
		if (run) begin
			drv <= 1'b1;
			if (cnt >= half) begin
				cnt <= 4'h0;
				lvl <= !lvl;
				if (!lvl)
					rises <= rises + 1;
			end else
				cnt <= cnt + 4'h1;
		end else begin
			lvl <= 1'b0;
			cnt <= 4'h0;
			if (!lvl)
				drv <= 1'b0;
		end
	end
endmodule

/* File: testbench/tb.sv */
// Testbench: registers, bit timing, sample position and sync clock pin
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import usbc_pkg::*;
	logic        core_clk, reset_n, wb_we, wb_cyc, wb_stb, wb_ack_o, d2_ack;
	logic [7:0]  wb_adr;
	logic [31:0] wb_dat_i, wb_dat_o, d2_dat, win;
	logic [3:0]  wb_sel, p_half;
	logic        rx_in, rx_restart, rx_bit_done, rx_bit_value;
	logic        pin_o, oe_n, strobe, p_drv, p_lvl, p_run, d2_oe_n;
	logic [4:0]  idx;
	wire logic   pin;
	int          fail_count, tests_run, seed, p_rises, strobes, s_rate;
	// Pin has a pull-down when nobody drives it
	assign pin = !oe_n ? pin_o : (p_drv ? p_lvl : 1'b0);
	usbc_top i_dut (.core_clk(core_clk), .reset_n(reset_n),
		.wb_adr_i(wb_adr), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel),
		.wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_in(rx_in),
		.rx_restart(rx_restart), .rx_bit_done(rx_bit_done),
		.rx_bit_value(rx_bit_value), .sync_clock_pin_i(pin),
		.sync_clock_pin_o(pin_o), .sync_clock_pin_oe_n(oe_n),
		.sync_bit_strobe(strobe));
	usbc_top #(.FIRST_INSTANCE(1'b0)) i_dut2 (.core_clk(core_clk),
		.reset_n(reset_n), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_dat_o(d2_dat), .wb_ack_o(d2_ack),
		.rx_in(rx_in), .rx_restart(rx_restart), .rx_bit_done(),
		.rx_bit_value(), .sync_clock_pin_i(pin), .sync_clock_pin_o(),
		.sync_clock_pin_oe_n(d2_oe_n), .sync_bit_strobe());
	usbc_far_end i_far (.core_clk(core_clk), .run(p_run), .half(p_half),
		.drv(p_drv), .lvl(p_lvl), .rises(p_rises));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(negedge core_clk) begin
		if (strobe === 1'b1)
			strobes++;
	end
	// Next oversample index, restarted and wrapped like the block's own
	function automatic logic [4:0] f_nxt(input logic [4:0] i);
		return (rx_restart === 1'b1 || i + 1 >= s_rate) ? 5'h00
			: i + 5'h01;
	endfunction
	// Serial line replays the window in step with the oversample index
	always @(posedge core_clk) begin
		idx <= f_nxt(idx);
		rx_in <= win[f_nxt(idx)];
	end
	function automatic int f_rate(int code);
		return (code < 7) ? 16 : code;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic [31:0] q2);
		int n;
		@(posedge core_clk);
		wb_adr <= a;
		wb_dat_i <= d;
		wb_we <= w;
		wb_sel <= 4'hf;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		n = 0;
		// Ack and read data taken at the rising edge that shows ack
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1);
		chk("ack latency", 32'd2, n);
		q = wb_dat_o;
		q2 = d2_dat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x, y;
		wb(1'b1, a, d, x, y);
	endtask
	// Count negedges until rx_bit_done (s=0) or sync_bit_strobe (s=1)
	task automatic wait_hi(input bit s, output int c);
		c = 0;
		do begin
			@(negedge core_clk);
			c++;
		end while ((s ? strobe : rx_bit_done) !== 1'b1 && c < 5000);
		if (c >= 5000)
			fail_count++;
	endtask
	task automatic restart();
		@(posedge core_clk);
		rx_restart <= 1'b1;
		@(posedge core_clk);
		rx_restart <= 1'b0;
	endtask
	task automatic test_regs();
		logic [7:0] ad[8] = '{ADR_CTRL, ADR_OVR, ADR_PSR, ADR_BAUD,
			ADR_MDSL2, ADR_SPOS, ADR_STAT, 8'h1c};
		logic [31:0] rv[8] = '{0, 0, 0, 0, 0, 32'h6, 0, 0};
		logic [31:0] q, q2;
		for (int i = 0; i < 8; i++) begin
			wb(1'b0, ad[i], 32'h0, q, q2);
			chk("reset value", rv[i], q);
		end
		wr(ADR_SPOS, 32'hffffffff);
		wb(1'b0, ADR_SPOS, 32'h0, q, q2);
		chk("position width", 32'h0f, q);
		wr(8'h1c, 32'hffffffff);
		wb(1'b0, 8'h1c, 32'h0, q, q2);
		chk("unmapped read", 32'h0, q);
		$display("register test done");
	endtask
	task automatic test_rate();
		int code, d, c, a, b, x;
		for (int k = 0; k < 6; k++) begin
			code = (k == 0) ? 3 : $unsigned($random(seed)) % 16;
			d = $unsigned($random(seed)) % 4;
			c = (k == 1) ? 1 : $unsigned($random(seed)) % 8;
			wr(ADR_OVR, code);
			wr(ADR_PSR, c);
			wr(ADR_BAUD, d);
			restart();
			wait_hi(1'b0, x);
			wait_hi(1'b0, x);
			wait_hi(1'b0, a);
			wait_hi(1'b0, b);
			chk("two bit span", f_rate(code) * (d + 1) * (c + 2), a + b);
		end
		$display("bit rate test done");
	endtask
	task automatic test_sample();
		int code, rate, pos, x;
		wr(ADR_PSR, 32'h0);
		wr(ADR_BAUD, 32'h0);
		for (int k = 0; k < 11; k++) begin
			code = (k == 0) ? 0 : k + 5;
			rate = f_rate(code);
			s_rate = rate;
			wr(ADR_OVR, code);
			for (int m = 0; m < 2; m++) begin
				pos = (k == 1) ? 0 : (k == 2) ? rate - 3 :
					$unsigned($random(seed)) % (rate - 2);
				if (m == 0) begin
					// Programmed value far from the automatic choice
					wr(ADR_SPOS, ((rate - 3) / 2 >= 4) ? 0 : rate - 3);
					pos = (rate - 3) / 2;
				end else
					wr(ADR_SPOS, pos);
				wr(ADR_MDSL2, m);
				for (int v = 0; v < 2; v++) begin
					// Middle sample dissents: only a vote at pos passes
					win = v ? (32'h5 << pos) : ~(32'h5 << pos);
					restart();
					repeat (3) wait_hi(1'b0, x);
					chk("bit value", v, rx_bit_value);
				end
			end
		end
		wr(ADR_MDSL2, 32'h0);
		$display("sample position test done");
	endtask
	task automatic test_sync();
		int d, c, a, p0;
		logic [31:0] q, q2;
		d = $unsigned($random(seed)) % 4;
		c = 2 * ($unsigned($random(seed)) % 4);
		wr(ADR_PSR, c);
		wr(ADR_BAUD, d);
		wr(ADR_CTRL, 32'h1);
		wb(1'b0, ADR_CTRL, 32'h0, q, q2);
		chk("ctrl second unit", 32'h0, q2);
		chk("ctrl first unit", 32'h1, q);
		wait_hi(1'b1, a);
		wait_hi(1'b1, a);
		chk("sync bit span", 2 * (d + 1) * (c + 2) / 2, a);
		chk("pin level", 1'b1, pin_o);
		chk("pin drive", 1'b0, oe_n);
		chk("second unit drive", 1'b1, d2_oe_n);
		wr(ADR_CTRL, 32'h3);
		repeat (4) @(posedge core_clk);
		chk("pin released", 1'b1, oe_n);
		p_half <= 1 + $unsigned($random(seed)) % 5;
		strobes = 0;
		p0 = p_rises;
		p_run <= 1'b1;
		repeat (200) @(posedge core_clk);
		p_run <= 1'b0;
		repeat (30) @(posedge core_clk);
		chk("external strobes", p_rises - p0, strobes);
		wr(ADR_CTRL, 32'h0);
		repeat (4) @(posedge core_clk);
		chk("async pin released", 1'b1, oe_n);
		$display("sync clock test done");
	endtask
	task automatic print_verdict();
		$display("compared %0d, wrong %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#3ms;
		fail_count++;
		print_verdict();
	end
	initial begin
		seed = 32'hf5e17cd7;
		fail_count = 0;
		tests_run = 0;
		strobes = 0;
		reset_n = 1'b0;
		{wb_we, wb_cyc, wb_stb, rx_restart, p_run} = 5'h00;
		wb_adr = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel = 4'h0;
		rx_in = 1'b1;
		win = 32'h0;
		idx = 5'h00;
		s_rate = 16;
		p_half = 4'h3;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		test_regs();
		test_rate();
		test_sample();
		test_sync();
		print_verdict();
	end
endmodule
